/* core_bus_master_model.sv */
`timescale 1ns/1ps
module core_bus_master_model (
	// clock
	input  wire logic        pclk,
	// core error events
	output logic             core_err_valid,
	output logic      [2:0]  core_err_kind,
	output logic      [31:0] core_err_addr,
	output logic             core_err_addr_eff,
	output logic      [31:0] core_err_pc,
	output logic             return_req,
	// memory events from any master
	output logic             mem_evt_valid,
	output logic             mem_evt_flash,
	output logic             mem_evt_multi,
	output logic      [31:0] mem_evt_addr,
	output logic      [3:0]  mem_evt_master,
	output logic      [7:0]  mem_evt_attr,
	output logic      [63:0] mem_evt_data
);
	initial begin
		{core_err_valid, core_err_kind, core_err_addr, core_err_addr_eff} = '0;
		{core_err_pc, return_req, mem_evt_valid, mem_evt_flash} = '0;
		{mem_evt_multi, mem_evt_addr, mem_evt_master, mem_evt_attr, mem_evt_data} = '0;
	end
	// one-cycle pulse; address and pc inverted afterwards so a stale hold is caught
	task core_err(input logic [2:0] k, input logic [31:0] a, input logic e,
		input logic [31:0] pc);
		@(posedge pclk);
		core_err_valid    <= 1'b1;
		core_err_kind     <= k;
		core_err_addr     <= a;
		core_err_addr_eff <= e;
		core_err_pc       <= pc;
		@(posedge pclk);
		core_err_valid <= 1'b0;
		core_err_addr  <= ~a;
		core_err_pc    <= ~pc;
	endtask : core_err
	// return from the handler once software is done
	task ret;
		@(posedge pclk);
		return_req <= 1'b1;
		@(posedge pclk);
		return_req <= 1'b0;
	endtask : ret
	// any crossbar master, not only the core
	task mem_evt(input logic f, input logic m, input logic [31:0] a,
		input logic [3:0] ms, input logic [7:0] at, input logic [63:0] d);
		@(posedge pclk);
		mem_evt_valid  <= 1'b1;
		mem_evt_flash  <= f;
		mem_evt_multi  <= m;
		mem_evt_addr   <= a;
		mem_evt_master <= ms;
		mem_evt_attr   <= at;
		mem_evt_data   <= d;
		@(posedge pclk);
		mem_evt_valid <= 1'b0;
		mem_evt_addr  <= ~a;
		mem_evt_data  <= ~d;
	endtask : mem_evt
endmodule : core_bus_master_model

/* ecc_capture_group.sv */
`timescale 1ns/1ps
module ecc_capture_group (
	// clock, reset and enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// event
	input  wire logic        capture,
	input  wire logic [31:0] addr,
	input  wire logic [3:0]  master,
	input  wire logic [7:0]  attr,
	input  wire logic [63:0] data,
	// held values
	output logic      [31:0] addr_ff,
	output logic      [3:0]  master_ff,
	output logic      [7:0]  attr_ff,
	output logic      [63:0] data_ff
);
	// most recent event overwrites the previous one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ff   <= 32'h0000_0000;
			master_ff <= 4'h0;
			attr_ff   <= 8'h00;
			data_ff   <= 64'h0000_0000_0000_0000;
		end else if (ce && capture) begin
			addr_ff   <= addr;
			master_ff <= master;
			attr_ff   <= attr;
			data_ff   <= data;
		end
	end
endmodule : ecc_capture_group

/* ecc_error_report_capture.sv */
`timescale 1ns/1ps
`include "ecc_map.svh"
module ecc_error_report_capture
	import ecc_pkg::*;
#(
	parameter bit HAS_MC_SAVE = 1'b1
) (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core error events
	input  wire logic        core_err_valid,
	input  wire logic [2:0]  core_err_kind,
	input  wire logic [31:0] core_err_addr,
	input  wire logic        core_err_addr_eff,
	input  wire logic [31:0] core_err_pc,
	input  wire logic        machine_check_enable,
	input  wire logic        return_req,
	output logic             mc_req,
	output logic             return_pc_valid,
	output logic      [31:0] return_pc,
	// memory ecc events from any master
	input  wire logic        mem_evt_valid,
	input  wire logic        mem_evt_flash,
	input  wire logic        mem_evt_multi,
	input  wire logic [31:0] mem_evt_addr,
	input  wire logic [3:0]  mem_evt_master,
	input  wire logic [7:0]  mem_evt_attr,
	input  wire logic [63:0] mem_evt_data,
	output logic             ecc_irq,
	// ram write path
	input  wire logic        ram_wr_valid,
	input  wire logic [63:0] ram_wr_data,
	input  wire logic [7:0]  ram_wr_check,
	output logic             ram_wr_out_valid,
	output logic      [63:0] ram_wr_out_data,
	output logic      [7:0]  ram_wr_out_check,
	// flash programming path
	input  wire logic        flash_prog_valid,
	input  wire logic [63:0] flash_prog_data,
	output logic             flash_prog_out_valid,
	output logic      [7:0]  flash_prog_out_check
);
	// ****************************************
	// apb handshake, one wait state
	// ****************************************
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        nxt_unmapped;
	logic        access;
	logic        commit;
	logic        wr_en;

	assign access = psel && penable;
	assign commit = access && pready_ff;
	assign wr_en  = commit && pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// ****************************************
	// register state
	// ****************************************
	logic [6:0]  synd_ff;
	logic [31:0] mcaddr_ff;
	logic [31:0] retaddr_ff;
	logic [7:0]  cfg_ff;
	logic [7:0]  stat_ff;
	logic [15:0] inj_ff;
	logic        mc_req_ff;
	logic        return_pc_valid_ff;
	logic [31:0] return_pc_ff;
	logic        irq_ff;
	logic [31:0] raddr_q;
	logic [3:0]  rmaster_q;
	logic [7:0]  rattr_q;
	logic [63:0] rdata_q;
	logic [31:0] faddr_q;
	logic [3:0]  fmaster_q;
	logic [7:0]  fattr_q;
	logic [63:0] fdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else if (ce) begin
			pready_ff  <= access && !pready_ff;
			pslverr_ff <= access && !pready_ff && nxt_unmapped;
			if (access && !pready_ff)
				prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
		end
	end

	always_comb begin
		nxt_prdata   = 32'h0000_0000;
		nxt_unmapped = 1'b0;
		unique case (paddr)
			`OFF_SYND:    nxt_prdata = {25'h0, synd_ff};
			`OFF_MCADDR:  nxt_prdata = mcaddr_ff;
			`OFF_RETADDR: nxt_prdata = retaddr_ff;
			`OFF_CFG:     nxt_prdata = {24'h0, cfg_ff};
			`OFF_STAT:    nxt_prdata = {24'h0, stat_ff};
			`OFF_INJ:     nxt_prdata = {16'h0, inj_ff};
			`OFF_RADDR:   nxt_prdata = raddr_q;
			`OFF_RATTR:   nxt_prdata = {20'h0, rmaster_q, rattr_q};
			`OFF_RDATL:   nxt_prdata = rdata_q[31:0];
			`OFF_RDATH:   nxt_prdata = rdata_q[63:32];
			`OFF_FADDR:   nxt_prdata = faddr_q;
			`OFF_FATTR:   nxt_prdata = {20'h0, fmaster_q, fattr_q};
			`OFF_FDATL:   nxt_prdata = fdata_q[31:0];
			`OFF_FDATH:   nxt_prdata = fdata_q[63:32];
			default:      nxt_unmapped = 1'b1;
		endcase
	end

	// ****************************************
	// machine check syndrome and address
	// ****************************************
	core_err_kind_type kind;
	logic [6:0] synd_set;
	logic [6:0] synd_clr;
	logic       addr_capture;

	assign kind = core_err_kind_type'(core_err_kind);

	always_comb begin
		synd_set = 7'h00;
		if (core_err_valid) begin
			synd_set[`SY_VALID] = 1'b1;
			unique case (kind)
				ERR_LOAD: begin
					synd_set[`SY_LOAD]  = 1'b1;
					synd_set[`SY_DRERR] = 1'b1;
				end
				ERR_SUBWRITE: begin
					synd_set[`SY_LOAD]  = 1'b1;
					synd_set[`SY_DRERR] = 1'b1;
					synd_set[`SY_WRERR] = 1'b1;
				end
				ERR_FETCH: begin
					synd_set[`SY_FETCH] = 1'b1;
					synd_set[`SY_IRERR] = 1'b1;
				end
				ERR_FILL_DATA: synd_set[`SY_DRERR] = 1'b1;
				ERR_FILL_INSN: synd_set[`SY_IRERR] = 1'b1;
				default:       synd_set = 7'h00;
			endcase
		end
	end

	assign synd_clr     = (wr_en && hit(paddr, `OFF_SYND)) ? (pwdata[6:0] & `SY_W1C_MASK) : 7'h00;
	// once captured, the address is frozen until software frees it
	assign addr_capture = core_err_valid && !synd_ff[`SY_VALID];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			synd_ff <= `RST_SYND;
		end else if (ce) begin
			synd_ff <= (synd_ff & ~synd_clr) | synd_set;
			if (addr_capture)
				synd_ff[`SY_ATYPE] <= core_err_addr_eff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mcaddr_ff <= 32'h0000_0000;
		else if (ce && addr_capture)
			mcaddr_ff <= core_err_addr;
	end

	// ****************************************
	// exception request and return address
	// ****************************************
	// other masters never reach this path; they are seen only below
	logic take_mc;
	assign take_mc = core_err_valid && machine_check_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mc_req_ff          <= 1'b0;
			retaddr_ff         <= 32'h0000_0000;
			return_pc_valid_ff <= 1'b0;
			return_pc_ff       <= 32'h0000_0000;
		end else if (ce) begin
			mc_req_ff          <= take_mc;
			return_pc_valid_ff <= return_req;
			if (take_mc)
				retaddr_ff <= core_err_pc;
			else if (wr_en && hit(paddr, `OFF_RETADDR))
				retaddr_ff <= pwdata;
			if (return_req)
				return_pc_ff <= retaddr_ff;
		end
	end

	// ****************************************
	// status unit: config, flags, interrupt
	// ****************************************
	logic [7:0] stat_set;
	logic [7:0] stat_clr;
	logic       ram_cap;
	logic       flash_cap;

	always_comb begin
		stat_set = 8'h00;
		if (mem_evt_valid) begin
			if (mem_evt_flash && mem_evt_multi)
				stat_set[`ST_FLASH_NC] = cfg_ff[`ST_FLASH_NC];
			if (mem_evt_flash && !mem_evt_multi)
				stat_set[`ST_FLASH_1B] = cfg_ff[`ST_FLASH_1B];
			if (!mem_evt_flash && mem_evt_multi)
				stat_set[`ST_RAM_NC] = cfg_ff[`ST_RAM_NC];
			if (!mem_evt_flash && !mem_evt_multi)
				stat_set[`ST_RAM_1B] = cfg_ff[`ST_RAM_1B];
		end
	end

	assign ram_cap   = stat_set[`ST_RAM_NC] || stat_set[`ST_RAM_1B];
	assign flash_cap = stat_set[`ST_FLASH_NC] || stat_set[`ST_FLASH_1B];
	assign stat_clr  = (wr_en && hit(paddr, `OFF_STAT)) ? (pwdata[7:0] & `ST_ALL_MASK) : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff  <= `RST_CFG;
			stat_ff <= `RST_STAT;
			irq_ff  <= 1'b0;
		end else if (ce) begin
			if (wr_en && hit(paddr, `OFF_CFG))
				cfg_ff <= pwdata[7:0] & `ST_ALL_MASK;
			// a new event in the clearing cycle survives
			stat_ff <= (stat_ff & ~stat_clr) | stat_set;
			irq_ff  <= |((stat_ff & ~stat_clr) | stat_set);
		end
	end

	ecc_capture_group u_ram_grp (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.capture   (ram_cap),
		.addr      (mem_evt_addr),
		.master    (mem_evt_master),
		.attr      (mem_evt_attr),
		.data      (mem_evt_data),
		.addr_ff   (raddr_q),
		.master_ff (rmaster_q),
		.attr_ff   (rattr_q),
		.data_ff   (rdata_q)
	);

	ecc_capture_group u_flash_grp (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.capture   (flash_cap),
		.addr      (mem_evt_addr),
		.master    (mem_evt_master),
		.attr      (mem_evt_attr),
		.data      (mem_evt_data),
		.addr_ff   (faddr_q),
		.master_ff (fmaster_q),
		.attr_ff   (fattr_q),
		.data_ff   (fdata_q)
	);

	// ****************************************
	// ram error injection
	// ****************************************
	// one-shot: the enable drops after the write it corrupted
	logic [71:0] inj_word;
	logic [71:0] flip_mask;
	logic        inj_hit;
	logic        ram_wr_out_valid_ff;
	logic [63:0] ram_wr_out_data_ff;
	logic [7:0]  ram_wr_out_check_ff;

	assign inj_hit   = ram_wr_valid && inj_ff[`INJ_EN_BIT];
	assign flip_mask = (inj_hit && inj_ff[`INJ_IDX_W-1:0] < 7'd72) ?
		(72'h1 << inj_ff[`INJ_IDX_W-1:0]) : 72'h0;
	assign inj_word  = {ram_wr_check, ram_wr_data} ^ flip_mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inj_ff              <= `RST_INJ;
			ram_wr_out_valid_ff <= 1'b0;
			ram_wr_out_data_ff  <= 64'h0000_0000_0000_0000;
			ram_wr_out_check_ff <= 8'h00;
		end else if (ce) begin
			if (wr_en && hit(paddr, `OFF_INJ))
				inj_ff <= pwdata[15:0];
			else if (inj_hit)
				inj_ff[`INJ_EN_BIT] <= 1'b0;
			ram_wr_out_valid_ff <= ram_wr_valid;
			if (ram_wr_valid) begin
				ram_wr_out_data_ff  <= inj_word[63:0];
				ram_wr_out_check_ff <= inj_word[71:64];
			end
		end
	end

	// ****************************************
	// flash checkbit encoder
	// ****************************************
	logic [7:0] flash_check;
	logic       flash_prog_out_valid_ff;
	logic [7:0] flash_prog_out_check_ff;

	ecc_flash_checkbits u_fchk (
		.data  (flash_prog_data),
		.check (flash_check)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_prog_out_valid_ff <= 1'b0;
			flash_prog_out_check_ff <= 8'h00;
		end else if (ce) begin
			flash_prog_out_valid_ff <= flash_prog_valid;
			if (flash_prog_valid)
				flash_prog_out_check_ff <= flash_check;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata               = prdata_ff;
	assign pready               = pready_ff;
	assign pslverr              = pslverr_ff;
	assign mc_req               = mc_req_ff;
	assign return_pc_valid      = return_pc_valid_ff;
	assign return_pc            = return_pc_ff;
	assign ecc_irq              = irq_ff;
	assign ram_wr_out_valid     = ram_wr_out_valid_ff;
	assign ram_wr_out_data      = ram_wr_out_data_ff;
	assign ram_wr_out_check     = ram_wr_out_check_ff;
	assign flash_prog_out_valid = flash_prog_out_valid_ff;
	assign flash_prog_out_check = flash_prog_out_check_ff;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_load_flags: assert property (
		ce && core_err_valid && kind == ERR_LOAD |=>
		synd_ff[`SY_VALID] && synd_ff[`SY_LOAD] && synd_ff[`SY_DRERR])
		else $error("load error flags missing");
	a_write_flags: assert property (
		ce && core_err_valid && kind == ERR_SUBWRITE |=>
		synd_ff[`SY_WRERR] && synd_ff[`SY_DRERR] && synd_ff[`SY_LOAD])
		else $error("write error flags missing");
	a_fetch_flags: assert property (
		ce && core_err_valid && kind == ERR_FETCH |=>
		synd_ff[`SY_FETCH] && synd_ff[`SY_IRERR] && synd_ff[`SY_VALID])
		else $error("fetch error flags missing");
	a_fill_flags: assert property (
		ce && core_err_valid && kind == ERR_FILL_INSN |=>
		synd_ff[`SY_VALID] && synd_ff[`SY_IRERR])
		else $error("line fill flags missing");
	a_addr_frozen: assert property (
		synd_ff[`SY_VALID] |=> $stable(mcaddr_ff))
		else $error("captured address overwritten");
	a_addr_taken: assert property (
		ce && addr_capture |=> mcaddr_ff == $past(core_err_addr) &&
		synd_ff[`SY_ATYPE] == $past(core_err_addr_eff))
		else $error("address or type not captured");
	a_return_pc: assert property (
		ce && take_mc ##1 ce && !take_mc && !wr_en ##1 ce && !take_mc && return_req |=>
		return_pc_valid && return_pc == $past(core_err_pc, 3))
		else $error("return address not restored");
	a_mc_gate: assert property (
		ce && core_err_valid |=> mc_req == $past(machine_check_enable))
		else $error("machine check gating wrong");
	a_ram_gate: assert property (
		ce && mem_evt_valid && !mem_evt_flash && mem_evt_multi && !stat_clr[`ST_RAM_NC] |=>
		stat_ff[`ST_RAM_NC] == $past(cfg_ff[`ST_RAM_NC]))
		else $error("ram report enable ignored");
	a_clear_all: assert property (
		ce && stat_clr == `ST_ALL_MASK && !mem_evt_valid |=> stat_ff == 8'h00 && !ecc_irq)
		else $error("status not cleared");
	a_inject_flip: assert property (
		ce && inj_hit && inj_ff[`INJ_IDX_W-1:0] == 7'd1 |=>
		ram_wr_out_data == ($past(ram_wr_data) ^ 64'h2) && !inj_ff[`INJ_EN_BIT])
		else $error("injected bit not inverted");
	a_erased_check: assert property (
		ce && flash_prog_valid && (flash_prog_data == 64'h0 || &flash_prog_data) |=>
		flash_prog_out_check == `ERASED_CHECK)
		else $error("erased pattern checkbits wrong");

	c_core_mc:   cover property (ce && take_mc ##1 mc_req);
	c_ram_nc:    cover property (ce && stat_set[`ST_RAM_NC] ##1 ecc_irq);
	c_inject:    cover property (ce && inj_hit);
	c_set_clear: cover property (ce && |(stat_set & stat_clr));
endmodule : ecc_error_report_capture

/* ecc_flash_checkbits.sv */
`timescale 1ns/1ps
module ecc_flash_checkbits (
	// data in
	input  wire logic [63:0] data,
	// checkbits out
	output logic      [7:0]  check
);
	// ****************************************
	// lane-symmetric parity
	// ****************************************
	// each mask has an even count of bits in every 16-bit lane,
	// so a lane of all ones adds nothing to any parity
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			localparam logic [15:0] LANE_MASK = 16'h0003 << i;
			assign check[i] = ~^(data & {4{LANE_MASK}});
		end
	endgenerate
endmodule : ecc_flash_checkbits

/* ecc_map.svh */
// Notes on behaviour
// - uncorrectable load sets valid, load, data-read flags
// - sub-word write on bad unit adds write flag
// - bad fetch sets valid, fetch, instruction-read flags
// - bad line fill sets valid plus read flag
// - address captured only while valid flag clear
// - address type bit tells effective or physical
// - exception saves faulting pc; return reloads it
// - machine check only when enabled, core events only
// - status unit reports ram and flash separately
// - last event address, master, attribute, data kept
// - write one clears flag; 0x33 clears all
// - ram reports gated by their enable bits
// - injection inverts selected bit of next ram write
// - lanes all ones or zeros give checkbits 0xff
// - without save register, critical return reloads pc
// - single-bit errors corrected, optionally reported
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFF_SYND     8'h00
`define OFF_MCADDR   8'h04
`define OFF_RETADDR  8'h08
`define OFF_CFG      8'h0c
`define OFF_STAT     8'h10
`define OFF_INJ      8'h14
`define OFF_RADDR    8'h18
`define OFF_RATTR    8'h1c
`define OFF_RDATL    8'h20
`define OFF_RDATH    8'h24
`define OFF_FADDR    8'h28
`define OFF_FATTR    8'h2c
`define OFF_FDATL    8'h30
`define OFF_FDATH    8'h34
// ****************************************
// syndrome fields
// ****************************************
`define SY_VALID     0
`define SY_ATYPE     1
`define SY_FETCH     2
`define SY_LOAD      3
`define SY_IRERR     4
`define SY_DRERR     5
`define SY_WRERR     6
`define SY_W1C_MASK  7'h7d
// ****************************************
// status and config fields
// ****************************************
`define ST_FLASH_NC  0
`define ST_RAM_NC    1
`define ST_FLASH_1B  4
`define ST_RAM_1B    5
`define ST_ALL_MASK  8'h33
`define INJ_EN_BIT   9
`define INJ_IDX_W    7
`define RST_CFG      8'h00
`define RST_STAT     8'h00
`define RST_INJ      16'h0000
`define RST_SYND     7'h00
`define ERASED_CHECK 8'hff
`endif

/* ecc_pkg.sv */
package ecc_pkg;
	typedef enum logic [2:0] {
		ERR_LOAD      = 3'b000,
		ERR_SUBWRITE  = 3'b001,
		ERR_FETCH     = 3'b010,
		ERR_FILL_DATA = 3'b011,
		ERR_FILL_INSN = 3'b100
	} core_err_kind_type;
endpackage : ecc_pkg

/* tb.sv */
`timescale 1ns/1ps
`include "ecc_map.svh"
module tb;
	import ecc_pkg::*;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, return_pc, r;
	logic pready, pslverr, mc_req, return_pc_valid, ecc_irq, err, mce = 0;
	logic ram_wr_valid = 0, ram_wr_out_valid, flash_prog_valid = 0, flash_prog_out_valid;
	logic [63:0] ram_wr_data = '0, flash_prog_data = '0, ram_wr_out_data, d;
	logic [7:0] ram_wr_check = '0, ram_wr_out_check, flash_prog_out_check, c;
	logic cv, ce_eff, rr, mv, mf, mm;
	logic [2:0] ck;
	logic [31:0] ca, cp, ma, a, pc;
	logic [3:0] mms;
	logic [7:0] mat, bse;
	logic [63:0] mdt;
	int n_errors = 0, num_checks = 0, k, b;
	integer seed = 32'h4048;
	always #12.5 pclk = ~pclk;
	core_bus_master_model u_core_bus_master_model (.pclk(pclk), .core_err_valid(cv),
		.core_err_kind(ck), .core_err_addr(ca), .core_err_addr_eff(ce_eff),
		.core_err_pc(cp), .return_req(rr), .mem_evt_valid(mv), .mem_evt_flash(mf),
		.mem_evt_multi(mm), .mem_evt_addr(ma), .mem_evt_master(mms),
		.mem_evt_attr(mat), .mem_evt_data(mdt));
	ecc_error_report_capture u_ecc_error_report_capture (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_err_valid(cv), .core_err_kind(ck), .core_err_addr(ca),
		.core_err_addr_eff(ce_eff), .core_err_pc(cp), .machine_check_enable(mce),
		.return_req(rr), .mc_req(mc_req), .return_pc_valid(return_pc_valid),
		.return_pc(return_pc), .mem_evt_valid(mv), .mem_evt_flash(mf),
		.mem_evt_multi(mm), .mem_evt_addr(ma), .mem_evt_master(mms),
		.mem_evt_attr(mat), .mem_evt_data(mdt), .ecc_irq(ecc_irq),
		.ram_wr_valid(ram_wr_valid), .ram_wr_data(ram_wr_data),
		.ram_wr_check(ram_wr_check), .ram_wr_out_valid(ram_wr_out_valid),
		.ram_wr_out_data(ram_wr_out_data), .ram_wr_out_check(ram_wr_out_check),
		.flash_prog_valid(flash_prog_valid), .flash_prog_data(flash_prog_data),
		.flash_prog_out_valid(flash_prog_out_valid),
		.flash_prog_out_check(flash_prog_out_check));
	task chk_val(input logic [63:0] got, input logic [63:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_val
	task chk_bit(input logic got, input logic exp, input string m);
		chk_val({63'h0, got}, {63'h0, exp}, m);
	endtask : chk_bit
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// request held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd_chk(input logic [7:0] ad, input logic [31:0] exp, input string m);
		apb(1'b0, ad, 32'h0);
		chk_val({32'h0, r}, {32'h0, exp}, m);
	endtask : rd_chk
	function automatic logic [6:0] synd_exp(input int kd);
		case (kd)
			0: return 7'h29;
			1: return 7'h69;
			2: return 7'h15;
			3: return 7'h21;
			default: return 7'h11;
		endcase
	endfunction : synd_exp
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`OFF_SYND, 32'h0, "synd reset");
		rd_chk(`OFF_CFG, 32'h0, "cfg reset");
		rd_chk(`OFF_STAT, 32'h0, "stat reset");
		rd_chk(`OFF_INJ, 32'h0, "inj reset");
		apb(1'b0, 8'h40, 32'h0);
		chk_bit(err, 1'b1, "unmapped err");
		$display("test reset done");
		mce <= 1'b1;
		for (k = 0; k < 5; k++) begin
			a = $random(seed);
			pc = $random(seed);
			b = $random(seed);
			u_core_bus_master_model.core_err(k[2:0], a, b[0], pc);
			#1 chk_bit(mc_req, 1'b1, "mc_req");
			apb(1'b0, `OFF_SYND, 32'h0);
			chk_val({57'h0, r[6:0] & 7'h7d}, {57'h0, synd_exp(k)}, "synd");
			chk_bit(r[1], b[0], "addr type");
			rd_chk(`OFF_MCADDR, a, "mcaddr");
			u_core_bus_master_model.core_err(3'd0, ~a, b[0], pc);
			rd_chk(`OFF_MCADDR, a, "mcaddr held");
			apb(1'b1, `OFF_SYND, 32'h7d);
			apb(1'b0, `OFF_SYND, 32'h0);
			chk_val({57'h0, r[6:0] & 7'h7d}, 64'h0, "synd cleared");
		end
		u_core_bus_master_model.core_err(3'd2, a, b[0], pc);
		u_core_bus_master_model.ret();
		#1 chk_bit(return_pc_valid, 1'b1, "ret valid");
		chk_val({32'h0, return_pc}, {32'h0, pc}, "ret pc");
		b = $random(seed);
		pc = pc + ((b[3] && !b[0]) ? 32'h4 : 32'h2);
		apb(1'b1, `OFF_RETADDR, pc);
		u_core_bus_master_model.ret();
		#1 chk_val({32'h0, return_pc}, {32'h0, pc}, "adjusted ret");
		mce <= 1'b0;
		u_core_bus_master_model.core_err(3'd0, a, 1'b0, pc);
		#1 chk_bit(mc_req, 1'b0, "mc_req masked");
		$display("test core done");
		u_core_bus_master_model.mem_evt(1'b0, 1'b1, a, 4'h1, 8'h2, 64'h3);
		#1 chk_bit(ecc_irq, 1'b0, "irq disabled");
		rd_chk(`OFF_STAT, 32'h0, "stat disabled");
		apb(1'b1, `OFF_CFG, 32'h33);
		for (k = 0; k < 4; k++) begin
			a = $random(seed);
			c = 8'($random(seed));
			d = {$random(seed), $random(seed)};
			b = k[0] ? (k[1] ? 0 : 4) : (k[1] ? 1 : 5);
			bse = k[0] ? `OFF_FADDR : `OFF_RADDR;
			u_core_bus_master_model.mem_evt(k[0], k[1], a, c[3:0], ~c, d);
			#1 chk_bit(ecc_irq, 1'b1, "irq set");
			rd_chk(`OFF_STAT, 32'h1 << b, "stat flag");
			rd_chk(bse, a, "evt addr");
			rd_chk(bse + 8'h4, {20'h0, c[3:0], ~c}, "evt attr");
			rd_chk(bse + 8'h8, d[31:0], "evt data lo");
			rd_chk(bse + 8'hc, d[63:32], "evt data hi");
			apb(1'b1, `OFF_STAT, 32'h1 << b);
			#1 chk_bit(ecc_irq, 1'b0, "irq cleared");
		end
		u_core_bus_master_model.mem_evt(1'b0, 1'b1, a, 4'h2, 8'h0, d);
		u_core_bus_master_model.mem_evt(1'b1, 1'b0, a, 4'h3, 8'h0, d);
		rd_chk(`OFF_STAT, 32'h12, "stat pair");
		rd_chk(`OFF_STAT, 32'h12, "stat stable");
		apb(1'b1, `OFF_STAT, 32'h33);
		rd_chk(`OFF_STAT, 32'h0, "clear all");
		apb(1'b1, `OFF_CFG, 32'h02);
		u_core_bus_master_model.mem_evt(1'b0, 1'b0, a, 4'h4, 8'h0, d);
		rd_chk(`OFF_STAT, 32'h0, "1b disabled");
		ce <= 1'b0;
		u_core_bus_master_model.mem_evt(1'b0, 1'b1, a, 4'h5, 8'h0, d);
		ce <= 1'b1;
		rd_chk(`OFF_STAT, 32'h0, "frozen by ce");
		$display("test status done");
		apb(1'b1, `OFF_INJ, 32'h201);
		for (k = 0; k < 2; k++) begin
			@(posedge pclk);
			ram_wr_valid <= 1'b1;
			ram_wr_data  <= d;
			ram_wr_check <= c;
			@(posedge pclk);
			ram_wr_valid <= 1'b0;
			ram_wr_data  <= ~d;
			#1 chk_bit(ram_wr_out_valid, 1'b1, "ram out valid");
			chk_val(ram_wr_out_data, (k == 0) ? d ^ 64'h2 : d, "ram out data");
			chk_val({56'h0, ram_wr_out_check}, {56'h0, c}, "ram out check");
		end
		apb(1'b0, `OFF_INJ, 32'h0);
		chk_bit(r[`INJ_EN_BIT], 1'b0, "inject one shot");
		for (k = 0; k < 16; k++) begin
			for (b = 0; b < 4; b++)
				d[16*b +: 16] = k[b] ? 16'hffff : 16'h0000;
			@(posedge pclk);
			flash_prog_valid <= 1'b1;
			flash_prog_data  <= d;
			@(posedge pclk);
			flash_prog_valid <= 1'b0;
			#1 chk_bit(flash_prog_out_valid, 1'b1, "prog valid");
			chk_val({56'h0, flash_prog_out_check}, 64'hff, "lane check");
		end
		$display("test write paths done");
		finish_test();
	end
endmodule : tb
